// file: rtl/gps_pm_pkg.sv
package gps_pm_pkg;

  // clock and derived cycle counts
  localparam int CLK_PERIOD_NS = 100;
  localparam int NS_PER_S = 1_000_000_000;
  localparam int SEC_CYC_DEF = NS_PER_S / CLK_PERIOD_NS;
  localparam int TOG_MIN_NS = 62_000;
  localparam int TOG_MIN_CYC =
    (TOG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TOG_MAX_S = 1;
  localparam int TOG_MAX_CYC_DEF = TOG_MAX_S * SEC_CYC_DEF;

  // counter widths
  localparam int SEC_W = 24;
  localparam int PER_W = 13;
  localparam int AGE_W = 18;
  localparam int CRED_W = 24;

  // times in seconds, figures as printed
  localparam int HOT_WIN_H = 2;
  localparam int PERIOD_DEF_MIN = 30;
  localparam int PERIOD_MIN_SEC = 10;
  localparam int PERIOD_MAX_H = 2;
  localparam int ORBIT_LIFE_D = 3;
  localparam logic [PER_W-1:0] HOT_WIN_S = PER_W'(HOT_WIN_H * 3600);
  localparam logic [PER_W-1:0] PERIOD_DEF = PER_W'(PERIOD_DEF_MIN * 60);
  localparam logic [PER_W-1:0] PERIOD_MIN = PER_W'(PERIOD_MIN_SEC);
  localparam logic [PER_W-1:0] PERIOD_MAX = PER_W'(PERIOD_MAX_H * 3600);
  localparam logic [AGE_W-1:0] ORBIT_LIFE_S = AGE_W'(ORBIT_LIFE_D * 86400);

  // quality-managed setting limits, plus the JAM_MAX cap on canceller lanes
  localparam logic [7:0] QINT_MIN = 8'h0A;
  localparam logic [7:0] QINT_MAX = 8'hB4;
  localparam logic [7:0] DUTY_MIN = 8'h05;
  localparam logic [7:0] DUTY_MAX = 8'h64;
  localparam logic [7:0] HERR_MAX = 8'hA0;
  localparam logic [3:0] JAM_MAX = 4'h8;

  // reset values
  localparam logic [7:0] QINT_RST = 8'h3C;
  localparam logic [7:0] DUTY_RST = 8'h32;
  localparam logic [7:0] HERR_RST = 8'h00;
  localparam logic [7:0] FIXCNT_RST = 8'h00;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_QINT = 8'h08;
  localparam logic [7:0] OFS_DUTY = 8'h0C;
  localparam logic [7:0] OFS_HERR = 8'h10;
  localparam logic [7:0] OFS_FIXCNT = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_FULL, ST_CPU, ST_STANDBY, ST_HIBERNATE
  } pwr_state_e;

  typedef enum logic [1:0] {
    POL_NONE, POL_ADAPTIVE, POL_PERIODIC, POL_QUALITY
  } policy_e;

  // sensor side events from the navigation engine
  typedef struct packed {
    logic meas_acquired;
    logic fix_done;
    logic [7:0] fix_err_m;
    logic signal_ok;
    logic orbit_created;
    logic [3:0] jammer_count;
  } nav_in_s;

  // power controls toward the rest of the receiver
  typedef struct packed {
    logic full_power_flag;
    logic rf_dsp_on;
    logic rf_dsp_partial;
    logic bb_clk_en;
    logic hot_start;
    logic orbit_valid;
    logic [7:0] jam_cancel_en;
  } pm_out_s;

  typedef struct packed {
    pwr_state_e pstate;
    policy_e policy;
    logic prio_interval;
    logic halted;
    logic missed;
    logic [PER_W-1:0] period;
    logic [7:0] fix_int;
    logic [7:0] duty;
    logic [7:0] herr;
    logic [7:0] fixcnt;
    logic [7:0] fixes_left;
    logic [SEC_W-1:0] sec_div;
    logic [PER_W-1:0] phase;
    logic [CRED_W-1:0] credit;
    logic had_fix;
    logic [PER_W-1:0] since_fix;
    logic have_orbit;
    logic [AGE_W-1:0] orbit_age;
    logic tog_prev;
    logic [SEC_W-1:0] tog_cnt;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    pm_out_s outs;
  } pm_state_s;

endpackage

// file: rtl/gps_power_mode_controller.sv
// Operation
// RULE1: stay in full power until a reliable position solution exists.
// RULE2: enter CPU-only once measurements are acquired, solution pending.
// RULE3: standby removes radio and DSP power and halts baseband clock.
// RULE4: hibernate keeps clock and memory; wake within two hours is hot.
// RULE5: adaptive policy cycles full, CPU-only and standby at fixed rate.
// RULE6: periodic policy hibernates, wakes every period, default 30 min.
// RULE7: periodic policy stays full power until a good fix is computed.
// RULE8: host toggle pulse wakes device, restarts periodic cycle defaults.
// RULE9: quality policy fix interval 10 to 180 s, priority selectable.
// RULE10: quality policy duty cycle setting from 5 to 100 percent.
// RULE11: quality policy horizontal error limit 1 to 160 m or undefined.
// RULE12: quality policy fix count up to 255, or continuous.
// RULE13: quality policy alternates only full power and hibernate.
// RULE14: duty priority lengthens off time after long on time.
// RULE15: interval priority stays full after missed fix until signal recovers.
// RULE16: cancel up to eight continuous-wave interferers.
// RULE17: locally predicted orbit valid three days, then expired.
// RULE18: full-power flag low in hibernate or standby, high in full power.
// RULE19: host toggle pulse longer than 62 us and shorter than 1 s.
// RULE20: valid toggle switches normal/hibernate, wakes periodic policy.
// RULE21: one policy at a time; new policy restarts in full power.
`timescale 1ns/1ns
module gps_power_mode_controller #(
  parameter int SEC_CYC = gps_pm_pkg::SEC_CYC_DEF,
  parameter int TOG_MAX_CYC = gps_pm_pkg::TOG_MAX_CYC_DEF,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // axi4-lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // host pins
  input wire logic manual_reset_low,
  input wire logic power_toggle,
  // navigation engine and power controls
  input wire gps_pm_pkg::nav_in_s nav,
  output gps_pm_pkg::pm_out_s pm
);
  import gps_pm_pkg::*;

  pm_state_s s_r;
  pm_state_s s_nxt;

  // defaults after either reset; also used by the manual reset pin
  function automatic pm_state_s reset_state();
    pm_state_s r;
    r = '0;
    r.pstate = ST_FULL;
    r.policy = POL_NONE;
    r.period = PERIOD_DEF;
    r.fix_int = QINT_RST;
    r.duty = DUTY_RST;
    r.herr = HERR_RST;
    r.fixcnt = FIXCNT_RST;
    r.fixes_left = FIXCNT_RST;
    r.outs.full_power_flag = 1'b1;
    r.outs.rf_dsp_on = 1'b1;
    r.outs.bb_clk_en = 1'b1;
    return r;
  endfunction

  // byte-lane merge of a write into the current word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] st);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return m;
  endfunction

  function automatic logic [7:0] clamp8(input logic [7:0] v,
                                        input logic [7:0] lo,
                                        input logic [7:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // register image as seen by software
  function automatic logic [31:0] reg_word(input pm_state_s st,
                                           input logic [7:0] ofs);
    logic [31:0] w;
    w = '0;
    unique case (ofs)
      OFS_CTRL: w = {29'h0, st.prio_interval, st.policy};
      OFS_PERIOD: w = {19'h0, st.period};
      OFS_QINT: w = {24'h0, st.fix_int};
      OFS_DUTY: w = {24'h0, st.duty};
      OFS_HERR: w = {24'h0, st.herr};
      OFS_FIXCNT: w = {24'h0, st.fixcnt};
      OFS_STATUS: w = {8'h0, st.fixes_left, 4'h0, nav.jammer_count,
                       st.missed, st.halted, st.outs.orbit_valid,
                       st.outs.hot_start, 2'h0, st.pstate};
      default: w = '0;
    endcase
    return w;
  endfunction

  function automatic logic mapped(input logic [7:0] ofs);
    return (ofs[1:0] == 2'h0) && (ofs <= OFS_STATUS);
  endfunction

  // handshake outputs straight from the holding flags
  assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready = !s_r.w_got && !s_r.bvalid;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rresp = s_r.rresp;
  assign s_axi_rdata = s_r.rdata;
  assign pm = s_r.outs;

  // next state of the whole block
  always_comb begin
    logic sec_tick;
    logic tog_ok;
    logic fix_good;
    logic [31:0] wv;
    logic [7:0] wofs;
    logic [7:0] rofs;
    sec_tick = 1'b0;
    tog_ok = 1'b0;
    fix_good = 1'b0;
    wv = '0;
    wofs = '0;
    rofs = '0;
    s_nxt = s_r;

    // one-second enable; the whole schedule counts in seconds
    sec_tick = (s_r.sec_div == SEC_W'(SEC_CYC - 1));
    s_nxt.sec_div = sec_tick ? '0 : s_r.sec_div + 1'b1;

    // toggle pulse width check on the falling edge
    s_nxt.tog_prev = power_toggle;
    if (power_toggle) begin
      if (s_r.tog_cnt != SEC_W'(TOG_MAX_CYC)) begin
        s_nxt.tog_cnt = s_r.tog_cnt + 1'b1;
      end
    end else begin
      s_nxt.tog_cnt = '0;
      tog_ok = s_r.tog_prev && (s_r.tog_cnt > SEC_W'(TOG_MIN_CYC))
               && (s_r.tog_cnt < SEC_W'(TOG_MAX_CYC)); // RULE19
    end

    // a fix counts only when within the error limit, 0 = undefined
    fix_good = nav.fix_done &&
               (s_r.herr == 8'h00 || nav.fix_err_m <= s_r.herr); // RULE11

    // time since last good fix and orbit file age
    if (fix_good) begin
      s_nxt.had_fix = 1'b1;
      s_nxt.since_fix = '0;
    end else if (sec_tick && s_r.since_fix < HOT_WIN_S) begin
      s_nxt.since_fix = s_r.since_fix + 1'b1;
    end
    if (nav.orbit_created) begin
      s_nxt.have_orbit = 1'b1;
      s_nxt.orbit_age = '0;
    end else if (sec_tick && s_r.orbit_age < ORBIT_LIFE_S) begin
      s_nxt.orbit_age = s_r.orbit_age + 1'b1; // RULE17
    end
    if (sec_tick && s_r.phase != PERIOD_MAX) begin
      s_nxt.phase = s_r.phase + 1'b1;
    end

    // policy schedules; each runs alone on the shared state
    if (!s_r.halted) begin
      unique case (s_r.policy)
        POL_NONE: s_nxt.pstate = ST_FULL; // RULE1
        POL_ADAPTIVE: begin
          unique case (s_r.pstate)
            ST_FULL: if (nav.meas_acquired) s_nxt.pstate = ST_CPU; // RULE2
            ST_CPU: if (fix_good) s_nxt.pstate = ST_STANDBY; // RULE5
            default: if (s_r.phase >= PER_W'(s_r.fix_int)) begin
              s_nxt.pstate = ST_FULL; // RULE5
              s_nxt.phase = '0;
            end
          endcase
        end
        POL_PERIODIC: begin
          if (s_r.pstate == ST_FULL) begin
            if (fix_good) begin
              s_nxt.pstate = ST_HIBERNATE; // RULE7
              s_nxt.phase = '0;
            end
          end else if (s_r.phase >= s_r.period) begin
            s_nxt.pstate = ST_FULL; // RULE6
            s_nxt.phase = '0;
          end
        end
        POL_QUALITY: begin
          if (s_r.pstate == ST_FULL) begin
            // duty credit grows while on, spent while off
            if (sec_tick && !s_r.prio_interval) begin
              s_nxt.credit = s_r.credit + CRED_W'(DUTY_MAX - s_r.duty);
            end
            if (s_r.prio_interval && s_r.phase >= PER_W'(s_r.fix_int)
                && !fix_good) begin
              s_nxt.missed = 1'b1; // RULE15
            end
            if (fix_good && (!s_r.missed || nav.signal_ok)) begin
              s_nxt.pstate = ST_HIBERNATE; // RULE13
              s_nxt.missed = 1'b0;
              if (s_r.missed) begin
                s_nxt.phase = '0; // RULE15
              end
              if (s_r.fixcnt != 8'h00) begin
                s_nxt.fixes_left = s_r.fixes_left - 1'b1; // RULE12
                s_nxt.halted = (s_r.fixes_left == 8'h01);
              end
            end
          end else if (s_r.prio_interval) begin
            if (s_r.phase >= PER_W'(s_r.fix_int)) begin
              s_nxt.pstate = ST_FULL; // RULE9
              s_nxt.phase = '0;
            end
          end else if (s_r.credit < CRED_W'(s_r.duty)) begin
            s_nxt.pstate = ST_FULL; // RULE10
            s_nxt.credit = '0;
          end else if (sec_tick) begin
            s_nxt.credit = s_r.credit - CRED_W'(s_r.duty); // RULE14
          end
        end
        default: s_nxt.pstate = ST_FULL;
      endcase
    end

    // host toggle: wake or sleep; periodic policy restarts on defaults
    if (tog_ok) begin
      s_nxt.phase = '0;
      if (s_r.policy == POL_PERIODIC) begin
        s_nxt.pstate = ST_FULL; // RULE8
        s_nxt.period = PERIOD_DEF; // RULE8
        s_nxt.halted = 1'b0;
      end else if (s_r.pstate == ST_HIBERNATE) begin
        s_nxt.pstate = ST_FULL; // RULE20
        s_nxt.halted = 1'b0;
        s_nxt.fixes_left = s_r.fixcnt;
      end else begin
        s_nxt.pstate = ST_HIBERNATE; // RULE20
        s_nxt.halted = 1'b1;
      end
    end

    // write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = 8'(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.aw_got && s_r.w_got) begin
      wofs = s_r.awaddr;
      wv = merge(reg_word(s_r, wofs), s_r.wdata, s_r.wstrb);
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = (mapped(wofs) && wofs != OFS_STATUS) ?
                    RESP_OKAY : RESP_SLVERR;
      unique case (wofs)
        OFS_CTRL: begin
          s_nxt.prio_interval = wv[2]; // RULE9
          if (policy_e'(wv[1:0]) != s_r.policy) begin
            s_nxt.policy = policy_e'(wv[1:0]); // RULE21
            s_nxt.pstate = ST_FULL; // RULE21
            s_nxt.phase = '0;
            s_nxt.credit = '0;
            s_nxt.missed = 1'b0;
            s_nxt.halted = 1'b0;
            s_nxt.fixes_left = s_r.fixcnt;
          end
        end
        OFS_PERIOD: begin
          s_nxt.period = (wv[PER_W-1:0] < PERIOD_MIN) ? PERIOD_MIN :
            ((wv[PER_W-1:0] > PERIOD_MAX) || (wv[31:PER_W] != '0)) ?
            PERIOD_MAX : wv[PER_W-1:0]; // RULE6
        end
        OFS_QINT: s_nxt.fix_int = clamp8(wv[7:0], QINT_MIN, QINT_MAX); // RULE9
        OFS_DUTY: s_nxt.duty = clamp8(wv[7:0], DUTY_MIN, DUTY_MAX); // RULE10
        OFS_HERR: s_nxt.herr = clamp8(wv[7:0], 8'h00, HERR_MAX); // RULE11
        OFS_FIXCNT: begin
          s_nxt.fixcnt = wv[7:0]; // RULE12
          s_nxt.fixes_left = wv[7:0];
        end
        default: ;
      endcase
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // read channel: one read answered at a time
    if (s_axi_arvalid && s_axi_arready) begin
      rofs = 8'(s_axi_araddr);
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = mapped(rofs) ? reg_word(s_r, rofs) : '0;
      s_nxt.rresp = mapped(rofs) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end

    // hot start judged at each wake from hibernate
    if (s_r.pstate == ST_HIBERNATE && s_nxt.pstate != ST_HIBERNATE) begin
      s_nxt.outs.hot_start = s_r.had_fix &&
                             (s_r.since_fix < HOT_WIN_S); // RULE4
    end

    // power controls follow the next state so they change with it
    s_nxt.outs.full_power_flag = (s_nxt.pstate == ST_FULL) ||
                                 (s_nxt.pstate == ST_CPU); // RULE18
    s_nxt.outs.rf_dsp_on = (s_nxt.pstate == ST_FULL);
    s_nxt.outs.rf_dsp_partial = (s_nxt.pstate == ST_CPU); // RULE2
    s_nxt.outs.bb_clk_en = (s_nxt.pstate == ST_FULL) ||
                           (s_nxt.pstate == ST_CPU); // RULE3
    s_nxt.outs.orbit_valid = s_nxt.have_orbit &&
                             (s_nxt.orbit_age < ORBIT_LIFE_S); // RULE17
    // interferer slots only while the radio is up; more than 8 saturate
    s_nxt.outs.jam_cancel_en = '0;
    for (int i = 0; i < 8; i++) begin
      if (s_nxt.outs.rf_dsp_on && (4'(i) < nav.jammer_count)
          && (4'(i) < JAM_MAX)) begin
        s_nxt.outs.jam_cancel_en[i] = 1'b1; // RULE16
      end
    end

    // manual reset pin restores every default, clocks included
    if (!manual_reset_low) begin
      s_nxt = reset_state();
    end
  end

  // single state register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= reset_state();
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

// file: tb/gps_pm_props.sv
`timescale 1ns/1ns
module gps_pm_props
  import gps_pm_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic manual_reset_low,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // engine side
  input wire gps_pm_pkg::nav_in_s nav,
  input wire gps_pm_pkg::pm_out_s pm
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // canceller lanes for a jammer count, saturating at eight
  function automatic logic [7:0] jmask(input logic [3:0] c);
    return (c > 4'h8) ? 8'hFF : 8'((9'h001 << c) - 9'h001);
  endfunction

  a_flag_clock: assert property (
    pm.full_power_flag == pm.bb_clk_en)
    else $error("power flag and clock enable disagree");
  a_standby_dark: assert property (
    !pm.full_power_flag |-> !(pm.rf_dsp_on || pm.rf_dsp_partial))
    else $error("radio powered in low-power state");
  a_rf_exclusive: assert property (
    !(pm.rf_dsp_on && pm.rf_dsp_partial))
    else $error("radio both full and partial");
  // lanes come back cleared from either reset, so skip the edge after one
  a_jam_lanes: assert property (
    $past(nrst) && $past(manual_reset_low) && pm.rf_dsp_on
    && $past(pm.rf_dsp_on) && $stable(nav.jammer_count)
    |-> pm.jam_cancel_en == jmask(nav.jammer_count))
    else $error("canceller lanes wrong");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");

  // main scenarios reached
  c_cpu_only: cover property (pm.rf_dsp_partial);
  c_low_power: cover property ($fell(pm.full_power_flag));
  c_refused: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

bind gps_power_mode_controller gps_pm_props chk (
  .core_clk(core_clk), .nrst(nrst), .manual_reset_low(manual_reset_low),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .nav(nav), .pm(pm));

// file: tb/gps_power_mode_controller_bench.sv
`timescale 1ns/1ns
module gps_power_mode_controller_bench;
  import gps_pm_pkg::*;
  logic core_clk = 1'h0;
  logic nrst = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rdv;
  logic power_toggle, manual_reset_low;
  nav_in_s nav = '0;
  pm_out_s pm;
  int failures = 0;
  int n_checks = 0;
  logic [7:0] ofs [6] = '{OFS_CTRL, OFS_PERIOD, OFS_QINT, OFS_DUTY,
                          OFS_HERR, OFS_FIXCNT};
  logic [31:0] rv [6] = '{32'h0, 32'h708, 32'h3C, 32'h32, 32'h0, 32'h0};
  logic [7:0] co [8] = '{OFS_PERIOD, OFS_PERIOD, OFS_QINT, OFS_QINT,
                         OFS_DUTY, OFS_DUTY, OFS_HERR, OFS_FIXCNT};
  logic [31:0] cw [8] = '{32'h5, 32'h1F40, 32'h5, 32'hC8, 32'h0, 32'h65,
                          32'hA1, 32'hFF};
  logic [31:0] ce [8] = '{32'hA, 32'h1C20, 32'hA, 32'hB4, 32'h5, 32'h64,
                          32'hA0, 32'hFF};

  always #50 core_clk = ~core_clk;

  // one-second tick and toggle ceiling shortened for simulation
  gps_power_mode_controller #(.SEC_CYC(20), .TOG_MAX_CYC(2000)) uut (
    .core_clk(core_clk), .nrst(nrst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .manual_reset_low(manual_reset_low),
    .power_toggle(power_toggle), .nav(nav), .pm(pm));

  host_pins_model host (.core_clk(core_clk), .power_toggle(power_toggle),
    .manual_reset_low(manual_reset_low));

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // address and data offered together, each dropped once taken;
  // waits for the answer, only the watchdog ends a hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    resp = bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    resp = rresp;
    rdv = rdata;
  endtask

  task automatic st(input logic [1:0] e);
    rd(OFS_STATUS);
    chk("state", {30'h0, e}, {30'h0, rdv[1:0]});
  endtask

  // one-cycle engine event pulse
  task automatic nv(input logic m, input logic f, input logic o,
                    input logic [7:0] e);
    @(posedge core_clk);
    nav.meas_acquired <= m;
    nav.fix_done <= f;
    nav.orbit_created <= o;
    nav.fix_err_m <= e;
    @(posedge core_clk);
    nav <= '{signal_ok: nav.signal_ok, jammer_count: nav.jammer_count,
             default: '0};
  endtask

  // bounded wait for the power flag; a miss is counted by chk
  task automatic wflag(input logic v, input int lim);
    for (int i = 0; i < lim && pm.full_power_flag !== v; i++)
      @(posedge core_clk);
    chk("power flag", {31'h0, v}, {31'h0, pm.full_power_flag});
  endtask

  task automatic end_of_test();
    if (failures == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // whole run is a few thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    end_of_test();
  end

  initial begin
    nav.signal_ok = 1'h1;
    nav.jammer_count = 4'hA;
    repeat (2) @(posedge core_clk);
    nrst <= 1'h1;
    for (int i = 0; i < 6; i++) begin
      rd(ofs[i]);
      chk("reset value", rv[i], rdv);
    end
    for (int i = 0; i < 8; i++) begin
      wr(co[i], cw[i]);
      rd(co[i]);
      chk("clamped", ce[i], rdv);
    end
    // only the strobed lane is written; low byte keeps its value
    wstrb <= 4'h2;
    wr(OFS_QINT, 32'h500);
    wstrb <= 4'hF;
    rd(OFS_QINT);
    chk("lane merge", 32'hB4, rdv);
    // refused writes and reads answer SLVERR; an unmapped read returns zero
    wr(8'h1C, 32'h1);
    chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    wr(OFS_STATUS, 32'h3);
    chk("status bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    rd(8'h1C);
    chk("unmapped rdata", 32'h0, rdv);
    chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    // adaptive cycling
    wr(OFS_QINT, 32'hA);
    wr(OFS_CTRL, 32'h1);
    st(2'h0);
    chk("jam lanes", 32'hFF, {24'h0, pm.jam_cancel_en});
    nav.jammer_count <= 4'h3;
    repeat (2) @(posedge core_clk);
    chk("jam lanes", 32'h07, {24'h0, pm.jam_cancel_en});
    nv(1'h1, 1'h0, 1'h0, 8'h00);
    st(2'h1);
    chk("cpu rails", 32'h3,
        {29'h0, pm.rf_dsp_on, pm.rf_dsp_partial, pm.bb_clk_en});
    wflag(1'h1, 1);
    nv(1'h0, 1'h1, 1'h0, 8'h00);
    st(2'h2);
    chk("standby rails", 32'h0,
        {29'h0, pm.rf_dsp_on, pm.rf_dsp_partial, pm.bb_clk_en});
    wflag(1'h0, 1);
    wflag(1'h1, 600);
    // periodic wake-up
    wr(OFS_PERIOD, 32'hA);
    wr(OFS_CTRL, 32'h2);
    repeat (300) @(posedge core_clk);
    st(2'h0);
    nv(1'h0, 1'h1, 1'h0, 8'h05);
    st(2'h3);
    wflag(1'h1, 600);
    rd(OFS_STATUS);
    chk("hot start", 32'h10, rdv & 32'h10);
    nv(1'h0, 1'h1, 1'h0, 8'h05);
    wflag(1'h0, 20);
    host.pulse(700);
    wflag(1'h1, 50);
    rd(OFS_PERIOD);
    chk("period default", 32'h708, rdv);
    // quality-managed: error limit, fix count, toggle length
    wr(OFS_HERR, 32'h5);
    wr(OFS_FIXCNT, 32'h1);
    wr(OFS_CTRL, 32'h7);
    nv(1'h0, 1'h1, 1'h0, 8'h32);
    st(2'h0);
    nv(1'h0, 1'h1, 1'h0, 8'h03);
    rd(OFS_STATUS);
    chk("halted", 32'h43, rdv & 32'h00FF00C3);
    host.pulse(100);
    st(2'h3);
    host.pulse(700);
    wflag(1'h1, 50);
    // missed interval under interval priority
    wr(OFS_FIXCNT, 32'h0);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, 32'h7);
    repeat (300) @(posedge core_clk);
    rd(OFS_STATUS);
    chk("missed", 32'h80, rdv & 32'h80);
    nav.signal_ok <= 1'h0;
    nv(1'h0, 1'h1, 1'h0, 8'h01);
    st(2'h0);
    nav.signal_ok <= 1'h1;
    nv(1'h0, 1'h1, 1'h0, 8'h01);
    st(2'h3);
    // predicted orbit freshly made
    nv(1'h0, 1'h0, 1'h1, 8'h00);
    rd(OFS_STATUS);
    chk("orbit valid", 32'h20, rdv & 32'h20);
    // duty priority: a long on time stretches the following off time
    wr(OFS_DUTY, 32'h32);
    wr(OFS_CTRL, 32'h3);
    wflag(1'h1, 20);
    repeat (100) @(posedge core_clk);
    nv(1'h0, 1'h1, 1'h0, 8'h01);
    st(2'h3);
    repeat (40) @(posedge core_clk);
    wflag(1'h0, 1);
    wflag(1'h1, 200);
    // manual reset back to defaults
    host.mreset();
    rd(OFS_CTRL);
    chk("ctrl after reset", 32'h0, rdv);
    st(2'h0);
    end_of_test();
  end
endmodule

// file: tb/host_pins_model.sv
`timescale 1ns/1ns
module host_pins_model (
  // clock
  input wire logic core_clk,
  // host pins
  output logic power_toggle,
  output logic manual_reset_low
);
  // toggle idles low, manual reset released high at time zero
  initial begin
    power_toggle = 1'h0;
    manual_reset_low = 1'h1;
  end

  // low-high-low toggle held high for n sampled edges
  task automatic pulse(input int n);
    @(posedge core_clk);
    power_toggle <= 1'h1;
    repeat (n) @(posedge core_clk);
    power_toggle <= 1'h0;
  endtask

  // one-edge manual reset, enough for a synchronous sampler
  task automatic mreset();
    @(posedge core_clk);
    manual_reset_low <= 1'h0;
    @(posedge core_clk);
    manual_reset_low <= 1'h1;
  endtask
endmodule
